// ===== ssctx_codec_model.sv
/*
 * model of the external codec: makes the transmit bit clock and
 * the frame sync that starts a transmit frame.
 * assumes clk_sys is the master clock of the block under test.
 */
`timescale 1ns/1ps
`default_nettype none
module ssctx_codec_model (
    // master clock and controls from the bench
    input  wire logic clk_sys,
    input  wire logic run,
    input  wire logic go,
    // pins towards the block
    output logic      sclk,
    output logic      fs
);
    int c = 0;
    // three-cycle levels keep the clock under half the master rate
    always @(posedge clk_sys)
    begin
        fs <= go;
        if (!run)
        begin
            sclk <= 1'b0; // still while run is low
            c    <= 0;
        end
        else if (c == 2)
        begin
            sclk <= ~sclk;
            c    <= 0;
        end
        else
            c <= c + 1;
    end
endmodule
`default_nettype wire

// ===== ssctx_divider.sv
/*
 * shared master-clock divider: a level that holds each state for
 * div_ratio master clock cycles, idle while the ratio is zero.
 * assumes div_ratio is synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssctx_params.svh"

module ssctx_divider #(
    parameter int DIV_W = `SSCTX_DIV_W
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    // ratio and divided level
    input  wire logic [DIV_W-1:0] div_ratio,
    output logic                  div_clk
);
    logic [DIV_W-1:0] cnt_reg;
    logic             div_clk_reg;
    logic             wrap;

    assign wrap    = (div_ratio != '0) && (cnt_reg >= div_ratio - 1'b1);
    assign div_clk = div_clk_reg;

    // counter restarts after ratio minus one; a ratio of zero parks it at zero
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            cnt_reg <= '0;
        else if (div_ratio == '0)
            cnt_reg <= '0;
        else if (wrap)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + 1'b1;
    end

    // toggling on each wrap gives n cycles per level, odd or even n
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            div_clk_reg <= 1'b0;
        else if (div_ratio == '0)
            div_clk_reg <= 1'b0;
        else if (wrap)
            div_clk_reg <= ~div_clk_reg;
    end

    // helper: length of the current level while the ratio stays put
    logic [DIV_W:0]   lvl_len_reg;
    logic             stable_reg;
    logic [DIV_W-1:0] ratio_prev_reg;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            lvl_len_reg    <= '0;
            stable_reg     <= 1'b0;
            ratio_prev_reg <= '0;
        end
        else
        begin
            ratio_prev_reg <= div_ratio;
            lvl_len_reg    <= wrap ? '0 : lvl_len_reg + 1'b1;
            if (div_ratio != ratio_prev_reg)
                stable_reg <= 1'b0;
            else if (wrap)
                stable_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    AST_DIV_IDLE: assert property ((div_ratio == '0) |=> (!div_clk_reg && cnt_reg == '0))
        else $error("divider not idle at zero ratio");
    AST_DIV_LEVEL: assert property ((wrap && stable_reg && div_ratio == ratio_prev_reg)
        |-> (lvl_len_reg + 1'b1 == {1'b0, div_ratio}))
        else $error("divided clock level length differs from ratio");
    AST_DIV_RANGE: assert property ((div_ratio != '0 && div_ratio == ratio_prev_reg
        && cnt_reg < div_ratio) |=> ($stable(div_ratio) -> cnt_reg < div_ratio))
        else $error("divider counter passed the ratio");
    COV_DIV_ODD: cover property ((div_ratio == 12'h003) ##1 $rose(div_clk_reg));
endmodule
`default_nettype wire

// ===== ssctx_params.svh
/*
 * constants of the serial clock and transmit block: clock-select codes,
 * clock-output modes, start modes and field widths.
 * assumes it is included by bare name from the design files.
 */
`ifndef SSCTX_PARAMS_SVH
`define SSCTX_PARAMS_SVH

// clock source select codes
`define SSCTX_SEL_PIN    2'h0
`define SSCTX_SEL_OTHER  2'h1
`define SSCTX_SEL_DIV    2'h2

// clock output modes of a clock pin
`define SSCTX_CKO_NONE   2'h0
`define SSCTX_CKO_CONT   2'h1
`define SSCTX_CKO_XFER   2'h2

// transmit start modes
`define SSCTX_ST_CONT    3'h0
`define SSCTX_ST_RXSYNC  3'h1
`define SSCTX_ST_FSFALL  3'h2
`define SSCTX_ST_FSRISE  3'h3
`define SSCTX_ST_FSLOW   3'h4
`define SSCTX_ST_FSHIGH  3'h5
`define SSCTX_ST_FSANY   3'h6

// widths and limits
`define SSCTX_DIV_W      12
`define SSCTX_WORD_W     32
`define SSCTX_BITCNT_W   5
`define SSCTX_WORDCNT_W  4
`define SSCTX_SYNC_W     16
`define SSCTX_SYNCCNT_W  4

`endif

// ===== ssctx_pkg.sv
/*
 * types of the serial clock and transmit block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package ssctx_pkg;
    // transmitter sequencing states
    typedef enum logic [1:0] {
        SSCTX_IDLE,
        SSCTX_WAIT_START,
        SSCTX_SYNC,
        SSCTX_DATA
    } ssctx_state_t;
endpackage

// ===== ssctx_top.sv
/*
 * clock management and transmit path of a synchronous serial
 * controller: clock selection, clock pin drive, holding and shift
 * registers, status flags and a masked interrupt line.
 * assumes all pins and controls are synchronous to clk_sys and that
 * external bit clocks run at most at half of clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssctx_params.svh"

// Operation
// - sides independent, each may borrow other's clock/start
// - transmit clock from pin, receive clock, divider
// - receive clock from pin, transmit clock, divider
// - twelve bit divider ratio with counter, comparator
// - zero ratio keeps divider idle
// - each divided level lasts ratio cycles
// - one divided clock feeds both selectors
// - transmit inversion affects internal clock only
// - transmit pin driven continuously or during transfer
// - receive pin drive modes; inversion internal only
// - frame starts on event, optional sync data
// - holding word moves into bit-clocked shift register
// - drained flag when holding and shift empty
// - free flag when holding moves to shift
// - unmasked pending event raises single interrupt
// - each interrupt source has its mask bit
// - continuous mode starts on holding write
// - up to sixteen words of 32 bits
module ssctx_top (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          nrst,
    // clock configuration
    input  wire logic [`SSCTX_DIV_W-1:0]       div_ratio,
    input  wire logic [1:0]                    tx_clock_source_select,
    input  wire logic [1:0]                    rx_clock_source_select,
    input  wire logic                          tx_clock_invert,
    input  wire logic                          rx_clock_invert,
    input  wire logic [1:0]                    tx_clock_output_mode,
    input  wire logic [1:0]                    rx_clock_output_mode,
    // transmit frame configuration
    input  wire logic [2:0]                    tx_start_mode,
    input  wire logic [`SSCTX_BITCNT_W-1:0]    tx_data_len,
    input  wire logic [`SSCTX_WORDCNT_W-1:0]   tx_data_num,
    input  wire logic                          tx_msb_first,
    input  wire logic                          tx_sync_enable,
    input  wire logic [`SSCTX_SYNCCNT_W-1:0]   tx_sync_len,
    input  wire logic [`SSCTX_SYNC_W-1:0]      tx_sync_data,
    input  wire logic                          tx_data_default,
    // transmit holding register write
    input  wire logic [`SSCTX_WORD_W-1:0]      transmit_holding_wdata,
    input  wire logic                          transmit_holding_write,
    // status and interrupt
    input  wire logic [1:0]                    irq_mask,
    output logic                               holding_free_flag,
    output logic                               transmitter_drained_flag,
    output logic                               irq,
    // receiver side coupling
    input  wire logic                          rx_start_pulse,
    input  wire logic                          rx_transfer_active,
    output logic                               rx_bit_clk,
    output logic                               tx_start_pulse,
    // transmit pins
    input  wire logic                          transmit_clock_pin_in,
    output logic                               transmit_clock_pin_out,
    output logic                               transmit_clock_pin_oe,
    input  wire logic                          transmit_frame_sync,
    output logic                               transmit_serial_out,
    // receive clock pin
    input  wire logic                          receive_clock_pin_in,
    output logic                               receive_clock_pin_out,
    output logic                               receive_clock_pin_oe
);
    ssctx_pkg::ssctx_state_t state_reg;

    logic                          div_clk;
    logic                          tx_raw, rx_raw, tx_src, rx_src, tx_int;
    logic                          tx_int_prev_reg, tick;
    logic                          tf_prev_reg, start_event, start_seen_reg, go;
    logic                          tx_busy, use_sync, load_now, word_end, frame_end;
    logic                          sync_done;
    logic [`SSCTX_WORD_W-1:0]      hold_reg, shift_reg;
    logic                          hold_full_reg;
    logic [`SSCTX_BITCNT_W-1:0]    bit_cnt_reg;
    logic [`SSCTX_WORDCNT_W-1:0]   word_cnt_reg;
    logic [`SSCTX_SYNCCNT_W-1:0]   sync_cnt_reg;
    logic                          td_reg, tk_out_reg, tk_oe_reg, rk_out_reg, rk_oe_reg;
    logic                          rx_bit_clk_reg, irq_reg, start_pulse_reg;

    // first serial bit of a word, by bit order and length
    function automatic logic first_bit(input logic [`SSCTX_WORD_W-1:0] w,
                                       input logic [`SSCTX_BITCNT_W-1:0] len,
                                       input logic msb);
        first_bit = msb ? w[len] : w[0];
    endfunction

    // word after one bit has gone out
    function automatic logic [`SSCTX_WORD_W-1:0] shifted(input logic [`SSCTX_WORD_W-1:0] w,
                                                         input logic msb);
        shifted = msb ? {w[`SSCTX_WORD_W-2:0], 1'b0} : {1'b0, w[`SSCTX_WORD_W-1:1]};
    endfunction

    // one divided clock, shared by both selectors
    ssctx_divider #(
        .DIV_W     (`SSCTX_DIV_W)
    ) ssctx_divider_i (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .div_ratio (div_ratio),
        .div_clk   (div_clk)
    );

    // each side's own source; borrowing takes the other's own source, so
    // two sides pointing at each other fall back to the divider, no loop
    assign tx_raw = (tx_clock_source_select == `SSCTX_SEL_PIN) ? transmit_clock_pin_in
                                                                : div_clk;
    assign rx_raw = (rx_clock_source_select == `SSCTX_SEL_PIN) ? receive_clock_pin_in
                                                                : div_clk;
    assign tx_src = (tx_clock_source_select == `SSCTX_SEL_OTHER) ? rx_raw : tx_raw;
    assign rx_src = (rx_clock_source_select == `SSCTX_SEL_OTHER) ? tx_raw : rx_raw;
    assign tx_int = tx_src ^ tx_clock_invert;

    // data changes on the falling edge of the internal transmit clock;
    // pin clocks are sampled on clk_sys, hence the half-rate limit
    assign tick = tx_int_prev_reg & ~tx_int;

    // clock pin drive, never inverted
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            tk_out_reg     <= 1'b0;
            tk_oe_reg      <= 1'b0;
            rk_out_reg     <= 1'b0;
            rk_oe_reg      <= 1'b0;
            rx_bit_clk_reg <= 1'b0;
        end
        else
        begin
            tk_out_reg     <= tx_src;
            tk_oe_reg      <= (tx_clock_output_mode == `SSCTX_CKO_CONT) ||
                              ((tx_clock_output_mode == `SSCTX_CKO_XFER) && tx_busy);
            rk_out_reg     <= rx_src;
            rk_oe_reg      <= (rx_clock_output_mode == `SSCTX_CKO_CONT) ||
                              ((rx_clock_output_mode == `SSCTX_CKO_XFER) &&
                               rx_transfer_active);
            rx_bit_clk_reg <= rx_src ^ rx_clock_invert;
        end
    end

    // edge history of the internal clock and the frame sync input
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_int_prev_reg <= 1'b0;
            tf_prev_reg     <= 1'b0;
        end
        else
        begin
            tx_int_prev_reg <= tx_int;
            tf_prev_reg     <= transmit_frame_sync;
        end
    end

    // start event decode
    always_comb
    begin
        case (tx_start_mode)
            `SSCTX_ST_CONT:   start_event = 1'b1;
            `SSCTX_ST_RXSYNC: start_event = rx_start_pulse;
            `SSCTX_ST_FSFALL: start_event = tf_prev_reg & ~transmit_frame_sync;
            `SSCTX_ST_FSRISE: start_event = ~tf_prev_reg & transmit_frame_sync;
            `SSCTX_ST_FSLOW:  start_event = ~transmit_frame_sync;
            `SSCTX_ST_FSHIGH: start_event = transmit_frame_sync;
            `SSCTX_ST_FSANY:  start_event = tf_prev_reg ^ transmit_frame_sync;
            default:          start_event = 1'b0;
        endcase
    end

    // sequencing terms; sync data is never sent in continuous mode
    assign go        = start_event | start_seen_reg;
    assign use_sync  = tx_sync_enable && (tx_start_mode != `SSCTX_ST_CONT);
    assign sync_done = (sync_cnt_reg == tx_sync_len);
    assign word_end  = (state_reg == ssctx_pkg::SSCTX_DATA) && (bit_cnt_reg == tx_data_len);
    assign frame_end = word_end && (word_cnt_reg == tx_data_num);
    assign load_now  = tick && hold_full_reg && (
                       ((state_reg == ssctx_pkg::SSCTX_WAIT_START) && go && !use_sync) ||
                       ((state_reg == ssctx_pkg::SSCTX_SYNC) && sync_done) ||
                       (word_end && !frame_end) ||
                       (frame_end && (tx_start_mode == `SSCTX_ST_CONT)));
    assign tx_busy   = (state_reg == ssctx_pkg::SSCTX_SYNC) ||
                       (state_reg == ssctx_pkg::SSCTX_DATA);

    // holding register: a write in the load cycle wins and stays full
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            hold_reg      <= '0;
            hold_full_reg <= 1'b0;
        end
        else if (transmit_holding_write)
        begin
            hold_reg      <= transmit_holding_wdata;
            hold_full_reg <= 1'b1;
        end
        else if (load_now)
            hold_full_reg <= 1'b0;
    end

    // frame sequencer and its counters
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg       <= ssctx_pkg::SSCTX_IDLE;
            start_seen_reg  <= 1'b0;
            bit_cnt_reg     <= '0;
            word_cnt_reg    <= '0;
            sync_cnt_reg    <= '0;
            start_pulse_reg <= 1'b0;
        end
        else
        begin
            start_pulse_reg <= 1'b0;
            case (state_reg)
                ssctx_pkg::SSCTX_IDLE:
                begin
                    start_seen_reg <= 1'b0;
                    if (hold_full_reg)
                        state_reg <= ssctx_pkg::SSCTX_WAIT_START;
                end
                ssctx_pkg::SSCTX_WAIT_START:
                begin
                    // edge events may fall between bit ticks: keep them
                    if (start_event)
                        start_seen_reg <= 1'b1;
                    if (tick && go)
                    begin
                        start_seen_reg  <= 1'b0;
                        start_pulse_reg <= 1'b1;
                        word_cnt_reg    <= '0;
                        bit_cnt_reg     <= '0;
                        sync_cnt_reg    <= '0;
                        state_reg       <= use_sync ? ssctx_pkg::SSCTX_SYNC
                                                    : ssctx_pkg::SSCTX_DATA;
                    end
                end
                ssctx_pkg::SSCTX_SYNC:
                begin
                    if (tick && !sync_done)
                        sync_cnt_reg <= sync_cnt_reg + 1'b1;
                    else if (tick)
                        state_reg <= ssctx_pkg::SSCTX_DATA;
                end
                ssctx_pkg::SSCTX_DATA:
                begin
                    if (tick && !word_end)
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    else if (tick && load_now)
                    begin
                        bit_cnt_reg     <= '0;
                        word_cnt_reg    <= frame_end ? '0 : word_cnt_reg + 1'b1;
                        start_pulse_reg <= frame_end;
                    end
                    else if (tick)
                        state_reg <= ssctx_pkg::SSCTX_IDLE; // underrun or frame done
                end
                default: state_reg <= ssctx_pkg::SSCTX_IDLE;
            endcase
        end
    end

    // shift register and serial data pin
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            shift_reg <= '0;
            td_reg    <= 1'b0;
        end
        else if (load_now)
        begin
            shift_reg <= shifted(hold_reg, tx_msb_first);
            td_reg    <= first_bit(hold_reg, tx_data_len, tx_msb_first);
        end
        else if (tick && (state_reg == ssctx_pkg::SSCTX_WAIT_START) && go && use_sync)
            td_reg <= tx_sync_data[0];
        else if (tick && (state_reg == ssctx_pkg::SSCTX_SYNC) && !sync_done)
            td_reg <= tx_sync_data[sync_cnt_reg + 1'b1];
        else if (tick && (state_reg == ssctx_pkg::SSCTX_DATA) && !word_end)
        begin
            shift_reg <= shifted(shift_reg, tx_msb_first);
            td_reg    <= first_bit(shift_reg, tx_data_len, tx_msb_first);
        end
        else if (tick && !tx_busy)
            td_reg <= tx_data_default;
        else if (tick && word_end)
            td_reg <= tx_data_default;
    end

    // status flags and the single masked interrupt line
    assign holding_free_flag        = ~hold_full_reg;
    assign transmitter_drained_flag = ~hold_full_reg & ~tx_busy;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            irq_reg <= 1'b0;
        else
            irq_reg <= |({transmitter_drained_flag, holding_free_flag} & irq_mask);
    end

    assign irq                    = irq_reg;
    assign tx_start_pulse         = start_pulse_reg;
    assign rx_bit_clk             = rx_bit_clk_reg;
    assign transmit_serial_out    = td_reg;
    assign transmit_clock_pin_out = tk_out_reg;
    assign transmit_clock_pin_oe  = tk_oe_reg;
    assign receive_clock_pin_out  = rk_out_reg;
    assign receive_clock_pin_oe   = rk_oe_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    AST_TK_FROM_DIV: assert property ((tx_clock_source_select == `SSCTX_SEL_DIV)
        |=> (transmit_clock_pin_out == $past(div_clk)))
        else $error("transmit clock pin not fed by divider");
    AST_RK_FROM_TX: assert property ((rx_clock_source_select == `SSCTX_SEL_OTHER &&
        tx_clock_source_select == `SSCTX_SEL_PIN)
        |=> (receive_clock_pin_out == $past(transmit_clock_pin_in)))
        else $error("receive clock does not follow transmit clock");
    AST_INV_INTERNAL: assert property ((tx_clock_source_select == `SSCTX_SEL_DIV &&
        rx_clock_source_select == `SSCTX_SEL_DIV)
        |=> (transmit_clock_pin_out == receive_clock_pin_out))
        else $error("inversion leaked to a clock pin");
    AST_RX_INV: assert property ((rx_clock_source_select == `SSCTX_SEL_DIV)
        |=> (rx_bit_clk == ($past(div_clk) ^ $past(rx_clock_invert))))
        else $error("internal receive clock wrong");
    AST_TK_OE_XFER: assert property ((tx_clock_output_mode == `SSCTX_CKO_XFER && !tx_busy)
        |=> !transmit_clock_pin_oe)
        else $error("transmit clock driven outside transfer");
    AST_DRAINED: assert property (transmit_holding_write |=> !transmitter_drained_flag)
        else $error("drained flag set with a word pending");
    AST_FREE_ON_LOAD: assert property ((load_now && !transmit_holding_write)
        |=> (holding_free_flag && state_reg == ssctx_pkg::SSCTX_DATA))
        else $error("holding free flag missing after load");
    AST_IRQ_MASK: assert property ((holding_free_flag && irq_mask[0]) |=> irq)
        else $error("unmasked event did not raise interrupt");
    AST_IRQ_QUIET: assert property ((irq_mask == 2'h0) |=> !irq)
        else $error("masked events raised interrupt");
    AST_CONT_START: assert property ((state_reg == ssctx_pkg::SSCTX_WAIT_START && tick &&
        tx_start_mode == `SSCTX_ST_CONT) |=> (state_reg == ssctx_pkg::SSCTX_DATA))
        else $error("continuous mode did not start");
    AST_WORD_LIMIT: assert property ((state_reg == ssctx_pkg::SSCTX_DATA &&
        $stable(tx_data_num)) |-> (word_cnt_reg <= tx_data_num))
        else $error("more words than programmed in frame");
    AST_SYNC_ONLY: assert property ((state_reg == ssctx_pkg::SSCTX_SYNC)
        |-> $past(use_sync) || $past(state_reg == ssctx_pkg::SSCTX_SYNC))
        else $error("sync data sent without enable");

    COV_FRAME: cover property (tx_start_pulse ##[1:1000] (state_reg == ssctx_pkg::SSCTX_IDLE));
    COV_SYNC: cover property ((state_reg == ssctx_pkg::SSCTX_SYNC) ##1
        (state_reg == ssctx_pkg::SSCTX_DATA));
    COV_BACK2BACK: cover property (word_end && load_now);
endmodule
`default_nettype wire

// ===== sync_serial_clock_and_tx_test.sv
/*
 * bench of the serial clock and transmit block: divider, clock pins,
 * framing and flags, with a codec model on the transmit pins.
 * assumes the design headers are compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssctx_params.svh"
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin bad_count++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module sync_serial_clock_and_tx_test;
    logic        clk_sys = '0, nrst = '0, tx_clock_invert = '0, rx_clock_invert = '1;
    logic        tx_msb_first = '1, tx_sync_enable = '0, tx_data_default = '0, run = '0, go = '0;
    logic        transmit_holding_write = '0, rx_start_pulse = '0, rx_transfer_active = '0;
    logic        receive_clock_pin_in = '0;
    logic [11:0] div_ratio = 12'h004;
    logic [1:0]  tx_clock_source_select = 2'h2, rx_clock_source_select = 2'h2, irq_mask = 2'h0;
    logic [1:0]  tx_clock_output_mode = 2'h1, rx_clock_output_mode = 2'h1;
    logic [2:0]  tx_start_mode = 3'h0;
    logic [4:0]  tx_data_len = 5'h07;
    logic [3:0]  tx_data_num = 4'h0, tx_sync_len = 4'h0;
    logic [15:0] tx_sync_data = '0;
    logic [31:0] transmit_holding_wdata = '0;
    wire logic   holding_free_flag, transmitter_drained_flag, irq, rx_bit_clk, tx_start_pulse;
    wire logic   transmit_clock_pin_in, transmit_clock_pin_out, transmit_clock_pin_oe;
    wire logic   transmit_frame_sync, transmit_serial_out, receive_clock_pin_out;
    wire logic   receive_clock_pin_oe;
    int          bad_count = 0, comparisons = 0, cyc = 0, n;
    ssctx_top ssctx_top_i (.*);
    ssctx_codec_model ssctx_codec_model_i (.clk_sys, .run, .go, .sclk(transmit_clock_pin_in),
        .fs(transmit_frame_sync));
    // clock, and a ceiling well above the several hundred cycles needed
    initial forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic finish_test();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr_word(input logic [31:0] w);
        transmit_holding_wdata = w;
        transmit_holding_write = 1'b1;
        tick(1);
        transmit_holding_write = 1'b0;
    endtask
    // bits are sampled at the pin's rise, mid-bit, clear of the shift edge
    task automatic get_bits(input logic [31:0] w, input int k);
        logic [31:0] got;
        logic p;
        got = '0;
        n = 0;
        for (int i = 0; i < k; i++)
        begin
            p = transmit_clock_pin_out;
            tick(1);
            while (!(transmit_clock_pin_out === 1 && p === 0) && n < 2000)
            begin
                p = transmit_clock_pin_out;
                tick(1);
                n++;
            end
            got = {got[30:0], transmit_serial_out};
        end
        `CHK("bits", w, got)
    endtask
    task automatic wait_start();
        n = 0;
        while (tx_start_pulse !== 1'b1 && n < 500)
        begin
            tick(1);
            n++;
        end
        `CHK("start", 1'b1, tx_start_pulse)
    endtask
    task automatic drain();
        n = 0;
        while (transmitter_drained_flag !== 1'b1 && n < 500)
        begin
            tick(1);
            n++;
        end
        `CHK("drained", 1'b1, transmitter_drained_flag)
    endtask
    initial
    begin
        tick(4);
        nrst = 1;
        tick(1);
        `CHK("free", 1'b1, holding_free_flag)
        `CHK("irq", 1'b0, irq)
        irq_mask = 2'h2;
        tick(2);
        `CHK("irq", 1'b1, irq)
        while (transmit_clock_pin_out !== 1'b0) tick(1);
        while (transmit_clock_pin_out !== 1'b1) tick(1);
        n = 0;
        while (transmit_clock_pin_out === 1'b1 && n < 50) begin tick(1); n++; end
        `CHK("level", 4, n)
        `CHK("oe", 1'b1, transmit_clock_pin_oe)
        `CHK("rxclk", ~receive_clock_pin_out, rx_bit_clk)
        `CHK("rkoe", 1'b1, receive_clock_pin_oe)
        div_ratio = 12'h000;
        tick(12);
        `CHK("idle", 1'b0, transmit_clock_pin_out)
        div_ratio = 12'h004;
        $display("test clocks done");
        wr_word(32'ha5);
        `CHK("drained", 1'b0, transmitter_drained_flag)
        wait_start();
        get_bits(32'ha5, 8);
        drain();
        tx_data_num = 4'h1;
        wr_word(32'h3c);
        wait_start();
        `CHK("free", 1'b1, holding_free_flag)
        wr_word(32'hc3);
        get_bits(32'h3cc3, 16);
        drain();
        tx_data_num = 4'h0;
        tx_data_len = 5'h1f;
        wr_word(32'h8123_4567);
        wait_start();
        get_bits(32'h8123_4567, 32);
        drain();
        $display("test divider frames done");
        tx_data_len = 5'h07;
        tx_clock_output_mode = `SSCTX_CKO_XFER;
        tx_clock_source_select = `SSCTX_SEL_PIN;
        rx_clock_source_select = `SSCTX_SEL_OTHER;
        rx_clock_output_mode = `SSCTX_CKO_XFER;
        tx_start_mode = `SSCTX_ST_FSRISE;
        run = 1'b1;
        wr_word(32'h5a);
        tick(30);
        `CHK("oe", 1'b0, transmit_clock_pin_oe)
        `CHK("rkoe", 1'b0, receive_clock_pin_oe)
        `CHK("drained", 1'b0, transmitter_drained_flag)
        go = 1'b1;
        rx_transfer_active = 1'b1;
        wait_start();
        get_bits(32'h5a, 8);
        `CHK("oe", 1'b1, transmit_clock_pin_oe)
        `CHK("rkoe", 1'b1, receive_clock_pin_oe)
        `CHK("rkclk", transmit_clock_pin_out, receive_clock_pin_out)
        go = 1'b0;
        rx_transfer_active = 1'b0;
        drain();
        tick(8);
        `CHK("oe", 1'b0, transmit_clock_pin_oe)
        // four sync bits, lsb first, then the word
        tx_sync_enable = 1'b1;
        tx_sync_len = 4'h3;
        tx_sync_data = 16'h0005;
        tx_data_default = 1'b1;
        tx_start_mode = `SSCTX_ST_FSFALL;
        go = 1'b1;
        wr_word(32'h5a);
        tick(10);
        go = 1'b0;
        wait_start();
        get_bits(32'ha5a, 12);
        drain();
        `CHK("default", 1'b1, transmit_serial_out)
        // frame started by the receiver, lsb first
        tx_sync_enable = 1'b0;
        tx_msb_first = 1'b0;
        tx_start_mode = `SSCTX_ST_RXSYNC;
        wr_word(32'h1e);
        tick(10);
        rx_start_pulse = 1'b1;
        tick(1);
        rx_start_pulse = 1'b0;
        wait_start();
        get_bits(32'h78, 8);
        drain();
        $display("test pin clock done");
        finish_test();
    end
endmodule
`default_nettype wire
